// *** rtl/iosc_ctrl.sv ***
// Sync and substitute-value control of a field I/O module.
// Assumes a station head on the local bus pins, from outside core_clk, and registers on AXI4-Lite.
// Contract
// - Capabilities show input and output sync support
// - Async mode samples/drives all data together
// - Report repeat, processing and run-up times
// - Without sync, transfer data immediately
// - Sync mode can be disabled by a control register bit
// - Power-on output until first valid data
// - Arm substitute after first valid exchange
// - Armed and data missing selects substitute
// - Decode 16-bit substitute code 0..3
// - Code 3 uses stored substitute data
`timescale 1ns/1ps
`default_nettype none
module iosc_ctrl #(
    parameter int DW = 32,
    parameter bit IN_SYNC_CAP = 1'b1,
    parameter bit OUT_SYNC_CAP = 1'b1,
    parameter logic [31:0] MIN_REPEAT_NS = 32'h0000_03E8,
    parameter logic [31:0] PROC_LEN_NS = 32'h0000_00C8,
    parameter logic [31:0] RUNUP_NS = 32'h0000_0064
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pd_valid,
    input wire logic [DW-1:0] pd_out_data,
    input wire logic sync_tick,
    input wire logic [DW-1:0] field_in,
    output logic [DW-1:0] field_out,
    output logic irq
);
    if (DW < 1 || DW > 32) begin : g_dw_check
        $error("DW must be 1..32");
    end

    // Pin inputs through two flops; stage one feeds only stage two
    logic [DW+1:0] s1_r, s2_r;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= {pd_valid, sync_tick, pd_out_data};
            s2_r <= s1_r;
        end
    end
    logic [DW-1:0] pin_data;
    logic pin_valid, pin_tick;
    assign pin_data = s2_r[DW-1:0];
    assign pin_tick = s2_r[DW];
    assign pin_valid = s2_r[DW+1];

    // Field input synchronised likewise
    logic [DW-1:0] fi1_r, fi2_r;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fi1_r <= '0;
            fi2_r <= '0;
        end else begin
            fi1_r <= field_in;
            fi2_r <= fi1_r;
        end
    end

    // Registers
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [15:0] code_r, code_nxt;
    logic [DW-1:0] subst_r, subst_nxt;
    logic [31:0] spoint_r, spoint_nxt;
    localparam int IRQ_W_L = iosc_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
    logic sync_en;
    assign sync_en = ctrl_r[iosc_pkg::CTRL_SYNC_EN_BIT];

    // Sync point counter: counts core_clk cycles after each tick
    logic [31:0] tcnt_r, tcnt_nxt;
    logic point_hit;
    assign point_hit = (tcnt_r == spoint_r);
    always_comb begin
        tcnt_nxt = tcnt_r;
        if (pin_tick) tcnt_nxt = '0;
        else if (tcnt_r != 32'hFFFF_FFFF) tcnt_nxt = tcnt_r + 32'h0000_0001;
    end

    // Data transfer: every bit at one instant or at once when sync is off
    logic xfer;
    assign xfer = sync_en ? point_hit : 1'b1;
    logic [DW-1:0] live_r, live_nxt, in_r, in_nxt;
    logic armed_r, armed_nxt;
    iosc_pkg::iosc_mode_t mode_r, mode_nxt;
    always_comb begin
        live_nxt = live_r;
        in_nxt = in_r;
        armed_nxt = armed_r;
        mode_nxt = mode_r;
        if (xfer) begin
            in_nxt = fi2_r;
            if (pin_valid) begin
                live_nxt = pin_data;
                armed_nxt = 1'b1;
                mode_nxt = iosc_pkg::IOSC_RUN;
            end else if (armed_r) begin
                mode_nxt = iosc_pkg::IOSC_SUBST;
            end
        end
        case (mode_r)
            iosc_pkg::IOSC_POWERON, iosc_pkg::IOSC_RUN, iosc_pkg::IOSC_SUBST: ;
            default: mode_nxt = iosc_pkg::IOSC_POWERON;
        endcase
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tcnt_r <= '0;
            live_r <= '0;
            in_r <= '0;
            armed_r <= 1'b0;
            mode_r <= iosc_pkg::IOSC_POWERON;
        end else begin
            tcnt_r <= tcnt_nxt;
            live_r <= live_nxt;
            in_r <= in_nxt;
            armed_r <= armed_nxt;
            mode_r <= mode_nxt;
        end
    end

    logic [DW-1:0] sel_out;
    iosc_out_sel #(.DW(DW)) u_sel (
        .mode(mode_r),
        .subst_code(code_r),
        .live_data(live_r),
        .held_data(live_r),
        .subst_data(subst_r),
        .out_value(sel_out)
    );
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) field_out <= '0;
        else field_out <= sel_out;
    end

    // Interrupt events
    logic ev_valid, ev_lost, ev_sync;
    assign ev_valid = xfer && pin_valid && !armed_r;
    assign ev_lost = xfer && !pin_valid && (mode_r == iosc_pkg::IOSC_RUN);
    assign ev_sync = sync_en && point_hit && pin_tick == 1'b0 && tcnt_r == spoint_r;
    assign irq = |(ist_r & imask_r);

    // AXI4-Lite write path: address and data accepted in either order
    logic aw_h_r, aw_h_nxt, w_h_r, w_h_nxt, bv_r, bv_nxt;
    logic [7:0] awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic [3:0] ws_r, ws_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    assign s_axi_awready = !aw_h_r && !bv_r;
    assign s_axi_wready = !w_h_r && !bv_r;
    assign s_axi_bvalid = bv_r;
    assign s_axi_bresp = bresp_r;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= iosc_pkg::OFS_IN_DATA);
    endfunction : mapped

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    endfunction : merge

    logic do_wr;
    assign do_wr = aw_h_r && w_h_r && !bv_r;
    always_comb begin
        aw_h_nxt = aw_h_r;
        w_h_nxt = w_h_r;
        awa_nxt = awa_r;
        wd_nxt = wd_r;
        ws_nxt = ws_r;
        bv_nxt = bv_r;
        bresp_nxt = bresp_r;
        ctrl_nxt = ctrl_r;
        code_nxt = code_r;
        subst_nxt = subst_r;
        spoint_nxt = spoint_r;
        imask_nxt = imask_r;
        ist_nxt = ist_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_h_nxt = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_h_nxt = 1'b1;
            wd_nxt = s_axi_wdata;
            ws_nxt = s_axi_wstrb;
        end
        if (do_wr) begin
            aw_h_nxt = 1'b0;
            w_h_nxt = 1'b0;
            bv_nxt = 1'b1;
            bresp_nxt = mapped(awa_r) ? iosc_pkg::RESP_OKAY : iosc_pkg::RESP_SLVERR;
            case (awa_r)
                iosc_pkg::OFS_CTRL: ctrl_nxt = merge(ctrl_r, wd_r, ws_r) & 32'h0000_0001;
                iosc_pkg::OFS_SUBST_CODE: code_nxt = 16'(merge({16'h0000, code_r}, wd_r, ws_r));
                iosc_pkg::OFS_SUBST_DATA: subst_nxt = DW'(merge(32'(subst_r), wd_r, ws_r));
                iosc_pkg::OFS_SYNC_POINT: spoint_nxt = merge(spoint_r, wd_r, ws_r);
                iosc_pkg::OFS_IRQ_MASK:
                    imask_nxt = IRQ_W_L'(merge(32'(imask_r), wd_r, ws_r));
                iosc_pkg::OFS_IRQ_STATUS: ist_nxt = ist_r & ~wd_r[IRQ_W_L-1:0];
                default: ;
            endcase
        end else if (bv_r && s_axi_bready) begin
            bv_nxt = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (ev_valid) ist_nxt[iosc_pkg::IRQ_VALID_BIT] = 1'b1;
        if (ev_lost) ist_nxt[iosc_pkg::IRQ_LOST_BIT] = 1'b1;
        if (ev_sync) ist_nxt[iosc_pkg::IRQ_SYNC_BIT] = 1'b1;
    end

    // Read path
    logic rv_r, rv_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    assign s_axi_arready = !rv_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rdata = rd_r;
    assign s_axi_rresp = rresp_r;
    always_comb begin
        rv_nxt = rv_r;
        rd_nxt = rd_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_nxt = 1'b1;
            rresp_nxt = mapped(s_axi_araddr) ? iosc_pkg::RESP_OKAY : iosc_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                iosc_pkg::OFS_CAPS: begin
                    rd_nxt = '0;
                    rd_nxt[iosc_pkg::CAP_IN_SYNC_BIT] = IN_SYNC_CAP;
                    rd_nxt[iosc_pkg::CAP_OUT_SYNC_BIT] = OUT_SYNC_CAP;
                end
                iosc_pkg::OFS_CTRL: rd_nxt = ctrl_r;
                iosc_pkg::OFS_STATUS: rd_nxt = {27'h0, mode_r, armed_r, sync_en};
                iosc_pkg::OFS_SUBST_CODE: rd_nxt = {16'h0000, code_r};
                iosc_pkg::OFS_SUBST_DATA: rd_nxt = 32'(subst_r);
                iosc_pkg::OFS_SYNC_POINT: rd_nxt = spoint_r;
                iosc_pkg::OFS_MIN_REPEAT: rd_nxt = MIN_REPEAT_NS;
                iosc_pkg::OFS_PROC_LEN: rd_nxt = PROC_LEN_NS;
                iosc_pkg::OFS_RUNUP: rd_nxt = RUNUP_NS;
                iosc_pkg::OFS_IRQ_STATUS: rd_nxt = 32'(ist_r);
                iosc_pkg::OFS_IRQ_MASK: rd_nxt = 32'(imask_r);
                iosc_pkg::OFS_OUT_DATA: rd_nxt = 32'(field_out);
                iosc_pkg::OFS_IN_DATA: rd_nxt = 32'(in_r);
                default: rd_nxt = '0;
            endcase
        end else if (rv_r && s_axi_rready) begin
            rv_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_h_r <= 1'b0;
            w_h_r <= 1'b0;
            awa_r <= '0;
            wd_r <= '0;
            ws_r <= '0;
            bv_r <= 1'b0;
            bresp_r <= iosc_pkg::RESP_OKAY;
            ctrl_r <= iosc_pkg::CTRL_RESET;
            code_r <= iosc_pkg::SUBST_CODE_RESET;
            subst_r <= '0;
            spoint_r <= '0;
            imask_r <= '0;
            ist_r <= '0;
            rv_r <= 1'b0;
            rd_r <= '0;
            rresp_r <= iosc_pkg::RESP_OKAY;
        end else begin
            aw_h_r <= aw_h_nxt;
            w_h_r <= w_h_nxt;
            awa_r <= awa_nxt;
            wd_r <= wd_nxt;
            ws_r <= ws_nxt;
            bv_r <= bv_nxt;
            bresp_r <= bresp_nxt;
            ctrl_r <= ctrl_nxt;
            code_r <= code_nxt;
            subst_r <= subst_nxt;
            spoint_r <= spoint_nxt;
            imask_r <= imask_nxt;
            ist_r <= ist_nxt;
            rv_r <= rv_nxt;
            rd_r <= rd_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // Checks
    chk_poweron_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        !armed_r |-> mode_r == iosc_pkg::IOSC_POWERON) else $error("output left power-on early");
    chk_arm_on_valid: assert property (@(posedge core_clk) disable iff (!arst_n)
        xfer && pin_valid |=> armed_r) else $error("not armed after valid data");
    chk_arm_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
        armed_r |=> armed_r) else $error("arm flag dropped");
    chk_subst_entry: assert property (@(posedge core_clk) disable iff (!arst_n)
        xfer && !pin_valid && armed_r |=> mode_r == iosc_pkg::IOSC_SUBST)
        else $error("no substitute on missing data");
    chk_zero_code: assert property (@(posedge core_clk) disable iff (!arst_n)
        mode_r == iosc_pkg::IOSC_SUBST && code_r == iosc_pkg::SUBST_ZERO |=> field_out == '0)
        else $error("zero code wrong");
    chk_final_code: assert property (@(posedge core_clk) disable iff (!arst_n)
        mode_r == iosc_pkg::IOSC_SUBST && code_r == iosc_pkg::SUBST_FINAL |=> field_out == '1)
        else $error("final code wrong");
    chk_subst_value: assert property (@(posedge core_clk) disable iff (!arst_n)
        mode_r == iosc_pkg::IOSC_SUBST && code_r == iosc_pkg::SUBST_VALUE
        |=> field_out == $past(subst_r)) else $error("substitute data not driven");
    chk_async_now: assert property (@(posedge core_clk) disable iff (!arst_n)
        !sync_en && pin_valid |=> live_r == $past(pin_data)) else $error("async late");
    chk_sync_point: assert property (@(posedge core_clk) disable iff (!arst_n)
        sync_en && !point_hit |=> $stable(live_r) && $stable(in_r))
        else $error("transfer off sync point");
endmodule : iosc_ctrl
`default_nettype wire

// *** rtl/iosc_pkg.sv ***
// Package for the I/O module sync and substitute-value control block.
// Assumes a single 50 MHz core clock and an AXI4-Lite register slave.
package iosc_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam logic [7:0] OFS_CAPS = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_SUBST_CODE = 8'h0C;
    localparam logic [7:0] OFS_SUBST_DATA = 8'h10;
    localparam logic [7:0] OFS_SYNC_POINT = 8'h14;
    localparam logic [7:0] OFS_MIN_REPEAT = 8'h18;
    localparam logic [7:0] OFS_PROC_LEN = 8'h1C;
    localparam logic [7:0] OFS_RUNUP = 8'h20;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    localparam logic [7:0] OFS_OUT_DATA = 8'h2C;
    localparam logic [7:0] OFS_IN_DATA = 8'h30;
    localparam int CAP_IN_SYNC_BIT = 0;
    localparam int CAP_OUT_SYNC_BIT = 1;
    localparam int CTRL_SYNC_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] SUBST_ZERO = 16'h0000;
    localparam logic [15:0] SUBST_FINAL = 16'h0001;
    localparam logic [15:0] SUBST_HOLD = 16'h0002;
    localparam logic [15:0] SUBST_VALUE = 16'h0003;
    localparam logic [15:0] SUBST_CODE_RESET = 16'h0000;
    localparam int IRQ_VALID_BIT = 0;
    localparam int IRQ_LOST_BIT = 1;
    localparam int IRQ_SYNC_BIT = 2;
    localparam int IRQ_W = 3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        IOSC_POWERON = 3'b001,
        IOSC_RUN = 3'b010,
        IOSC_SUBST = 3'b100
    } iosc_mode_t;
endpackage : iosc_pkg

// *** rtl/iosc_out_sel.sv ***
// Output value selector: power-on, live, and substitute value modes.
// Assumes the caller supplies the current mode and held value on core_clk.
`timescale 1ns/1ps
`default_nettype none
module iosc_out_sel #(
    parameter int DW = 32
) (
    input wire logic [2:0] mode,
    input wire logic [15:0] subst_code,
    input wire logic [DW-1:0] live_data,
    input wire logic [DW-1:0] held_data,
    input wire logic [DW-1:0] subst_data,
    output logic [DW-1:0] out_value
);
    always_comb begin
        out_value = '0;
        case (mode)
            iosc_pkg::IOSC_POWERON: out_value = '0;
            iosc_pkg::IOSC_RUN: out_value = live_data;
            iosc_pkg::IOSC_SUBST: begin
                case (subst_code)
                    iosc_pkg::SUBST_ZERO: out_value = '0;
                    iosc_pkg::SUBST_FINAL: out_value = '1;
                    iosc_pkg::SUBST_HOLD: out_value = held_data;
                    iosc_pkg::SUBST_VALUE: out_value = subst_data;
                    default: out_value = '0;
                endcase
            end
            default: out_value = '0;
        endcase
    end
endmodule : iosc_out_sel
`default_nettype wire

// *** bench/iosc_head_model.sv ***
// Station head stand-in: drives process data, its valid flag and the cycle tick.
// Assumes the bench steers it through send, data and tick_req on core_clk.
`timescale 1ns/1ps
`default_nettype none
module iosc_head_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic send,
    input wire logic [31:0] data,
    input wire logic tick_req,
    output logic pd_valid,
    output logic [31:0] pd_out_data,
    output logic sync_tick
);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pd_valid <= 1'b0;
            pd_out_data <= 32'h0;
            sync_tick <= 1'b0;
        end else begin
            pd_valid <= send;
            // Released data keeps toggling so a stale word never looks current
            pd_out_data <= send ? data : ~pd_out_data;
            // Tick follows tick_req one core_clk later, whatever the module's sync setting
            sync_tick <= tick_req;
        end
    end
endmodule : iosc_head_model
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the sync and substitute-value control block.
// Assumes one core clock; the head model stands on the local bus side.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, send, tick_req, pd_valid, sync_tick, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, field_in, field_out, hd_data, pd_out_data, rd, last_live, subst;
    logic [1:0] bresp, rresp;
    int miscompares, tests_run, c;
    iosc_ctrl dut (.core_clk(core_clk), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pd_valid(pd_valid), .pd_out_data(pd_out_data),
        .sync_tick(sync_tick), .field_in(field_in), .field_out(field_out), .irq(irq));
    iosc_head_model head (.core_clk(core_clk), .arst_n(arst_n), .send(send), .data(hd_data),
        .tick_req(tick_req), .pd_valid(pd_valid), .pd_out_data(pd_out_data),
        .sync_tick(sync_tick));
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic timed_out();
        miscompares++;
        $display("unexpected handshake wait expired");
        print_verdict();
    endtask : timed_out
    task automatic chk_data(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk_data
    task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask : chk_resp
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (i == 40) timed_out();
        bready <= 1'b0;
        chk_resp("bresp", er, bresp);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (i == 40) timed_out();
        d = rdata;
        rready <= 1'b0;
        chk_resp("rresp", er, rresp);
    endtask : axi_rd
    // The head flop, two sync stages, the transfer and the output register need five of the six edges
    task automatic drive(input logic v, input logic [31:0] d);
        @(posedge core_clk);
        send <= v;
        hd_data <= d;
        if (v) last_live = d;
        repeat (6) @(posedge core_clk);
    endtask : drive
    function automatic logic [31:0] model_out(input int code);
        case (code)
            1: return 32'hFFFF_FFFF;
            2: return last_live;
            3: return subst;
            default: return 32'h0;
        endcase
    endfunction : model_out
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input string n);
        axi_rd(a, rd, iosc_pkg::RESP_OKAY);
        chk_data(n, e, rd);
    endtask : chk_reg
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready, send, tick_req} = '0;
        {awaddr, araddr, wdata, hd_data} = '0;
        miscompares = 0;
        tests_run = 0;
        void'($urandom(32'h37BF_5BF8));
        field_in = $urandom();
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        axi_rd(iosc_pkg::OFS_CAPS, rd, iosc_pkg::RESP_OKAY);
        chk_data("caps", 32'h3, rd & 32'h3);
        chk_reg(iosc_pkg::OFS_MIN_REPEAT, 32'h0000_03E8, "min_repeat");
        chk_reg(iosc_pkg::OFS_PROC_LEN, 32'h0000_00C8, "proc_len");
        chk_reg(iosc_pkg::OFS_RUNUP, 32'h0000_0064, "runup");
        chk_reg(iosc_pkg::OFS_STATUS, 32'h04, "status");
        axi_rd(8'h3C, rd, iosc_pkg::RESP_SLVERR);
        axi_wr(8'h3C, 32'h1, iosc_pkg::RESP_SLVERR);
        // Final-value code before any data: outputs must still stay at power-on
        axi_wr(iosc_pkg::OFS_SUBST_CODE, 32'h1, iosc_pkg::RESP_OKAY);
        repeat (10) @(posedge core_clk);
        chk_data("field_out", 32'h0, field_out);
        drive(1'b1, $urandom());
        chk_data("field_out", last_live, field_out);
        chk_reg(iosc_pkg::OFS_IN_DATA, field_in, "in_data");
        chk_reg(iosc_pkg::OFS_STATUS, 32'h0A, "status");
        chk_reg(iosc_pkg::OFS_IRQ_STATUS, 32'h1, "irq_status");
        axi_wr(iosc_pkg::OFS_IRQ_MASK, 32'h2, iosc_pkg::RESP_OKAY);
        for (c = 0; c < 5; c++) begin
            subst = $urandom();
            axi_wr(iosc_pkg::OFS_SUBST_CODE, 32'(c), iosc_pkg::RESP_OKAY);
            axi_wr(iosc_pkg::OFS_SUBST_DATA, subst, iosc_pkg::RESP_OKAY);
            field_in <= $urandom();
            drive(1'b1, $urandom());
            chk_data("field_out", last_live, field_out);
            drive(1'b0, 32'h0);
            chk_data("field_out", model_out(c), field_out);
            chk_data("irq", 32'h1, {31'h0, irq});
            chk_reg(iosc_pkg::OFS_STATUS, 32'h12, "status");
            axi_wr(iosc_pkg::OFS_IRQ_STATUS, 32'h2, iosc_pkg::RESP_OKAY);
            chk_data("irq", 32'h0, {31'h0, irq});
        end
        drive(1'b1, $urandom());
        axi_wr(iosc_pkg::OFS_SYNC_POINT, 32'hA, iosc_pkg::RESP_OKAY);
        axi_wr(iosc_pkg::OFS_CTRL, 32'h1, iosc_pkg::RESP_OKAY);
        rd = last_live;
        drive(1'b1, $urandom());
        chk_data("field_out", rd, field_out);
        @(posedge core_clk);
        tick_req <= 1'b1;
        @(posedge core_clk);
        tick_req <= 1'b0;
        repeat (20) @(posedge core_clk);
        chk_data("field_out", last_live, field_out);
        chk_reg(iosc_pkg::OFS_IRQ_STATUS, 32'h5, "irq_status");
        axi_wr(iosc_pkg::OFS_CTRL, 32'h0, iosc_pkg::RESP_OKAY);
        drive(1'b1, $urandom());
        chk_data("field_out", last_live, field_out);
        chk_reg(iosc_pkg::OFS_OUT_DATA, last_live, "out_data");
        @(posedge core_clk);
        arst_n <= 1'b0;
        send <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        chk_data("field_out", 32'h0, field_out);
        chk_reg(iosc_pkg::OFS_STATUS, 32'h04, "status");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
